// ### core/gjkff_core.sv
// gated master-slave j-k flop sampled on the system clock
`timescale 1ns/1ps
`default_nettype none
module gjkff_core #(
  parameter logic INV_GATING = 1'h0
) (
  input  wire logic clk_i,
  input  wire logic resetn_i,
  input  wire logic flop_clk_i,
  input  wire logic common_gate_enable_i,
  input  wire logic set_gate_in_a_i,
  input  wire logic set_gate_in_b_i,
  input  wire logic set_gate_in_c_i,
  input  wire logic reset_gate_in_a_i,
  input  wire logic reset_gate_in_b_i,
  input  wire logic reset_gate_in_c_i,
  input  wire logic async_preset_n_i,
  input  wire logic async_clear_n_i,
  output logic      q_o,
  output logic      q_n_o
);

  gjkff_pkg::gjkff_state_t st_ff;
  gjkff_pkg::gjkff_state_t nxt_st;
  logic [gjkff_pkg::N_PINS-1:0] pins;
  logic [gjkff_pkg::N_PINS-1:0] nxt_filt;
  logic set_term;
  logic rst_term;
  logic clk_lvl;
  logic rise;
  logic pre_act;
  logic clr_act;
  logic set_acc;
  logic rst_acc;

  assign pins = {async_clear_n_i, async_preset_n_i,
                 reset_gate_in_c_i, reset_gate_in_b_i, reset_gate_in_a_i,
                 set_gate_in_c_i, set_gate_in_b_i, set_gate_in_a_i,
                 common_gate_enable_i, flop_clk_i};

  // a pin change counts only once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < gjkff_pkg::N_PINS; gi++) begin : g_filt
      assign nxt_filt[gi] = (st_ff.s2[gi] == st_ff.s3[gi]) ? st_ff.s3[gi] : st_ff.filt[gi];
    end
  endgenerate

  // b input inverted in the inverting variant
  assign set_term = st_ff.filt[gjkff_pkg::IDX_GATE] & st_ff.filt[gjkff_pkg::IDX_SA]
                  & (st_ff.filt[gjkff_pkg::IDX_SB] ^ INV_GATING)
                  & st_ff.filt[gjkff_pkg::IDX_SC];
  assign rst_term = st_ff.filt[gjkff_pkg::IDX_GATE] & st_ff.filt[gjkff_pkg::IDX_RA]
                  & (st_ff.filt[gjkff_pkg::IDX_RB] ^ INV_GATING)
                  & st_ff.filt[gjkff_pkg::IDX_RC];
  assign clk_lvl = st_ff.filt[gjkff_pkg::IDX_CLK];
  assign rise    = clk_lvl & ~st_ff.clk_prev;
  assign pre_act = ~st_ff.filt[gjkff_pkg::IDX_PRE];
  assign clr_act = ~st_ff.filt[gjkff_pkg::IDX_CLR];
  // sticky capture: a transient high during clock low is remembered
  assign set_acc = st_ff.set_cap | set_term;
  assign rst_acc = st_ff.rst_cap | rst_term;

  always_comb begin
    nxt_st          = st_ff;
    nxt_st.s1       = pins;
    nxt_st.s2       = st_ff.s1;
    nxt_st.s3       = st_ff.s2;
    nxt_st.filt     = nxt_filt;
    nxt_st.clk_prev = clk_lvl;
    if (!clk_lvl) begin
      nxt_st.set_cap = set_acc;
      nxt_st.rst_cap = rst_acc;
      case ({set_acc, rst_acc})
        2'h0:    nxt_st.master = st_ff.q;
        2'h1:    nxt_st.master = 1'h0;
        2'h2:    nxt_st.master = 1'h1;
        default: nxt_st.master = ~st_ff.q;
      endcase
    end else if (rise) begin
      // high phase loads nothing, so the master is frozen here
      nxt_st.q       = st_ff.master;
      nxt_st.qn      = ~st_ff.master;
      nxt_st.set_cap = 1'h0;
      nxt_st.rst_cap = 1'h0;
    end
    // both active drives both outputs high, an undefined pairing for the driver
    if (pre_act || clr_act) begin
      nxt_st.master  = pre_act & ~clr_act;
      nxt_st.q       = pre_act;
      nxt_st.qn      = clr_act;
      nxt_st.set_cap = 1'h0;
      nxt_st.rst_cap = 1'h0;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_ff <= gjkff_pkg::STATE_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign q_o   = st_ff.q;
  assign q_n_o = st_ff.qn;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);

  AST_HIGH_IGNORED: assert property (
    (clk_lvl && !rise && !pre_act && !clr_act) |=> ($stable(q_o) && $stable(st_ff.master))
  ) else $error("state moved while flop clock high");

  AST_RISE_TRANSFER: assert property (
    (rise && !pre_act && !clr_act) |=> (q_o == $past(st_ff.master) && q_n_o == !q_o)
  ) else $error("rising edge did not move master to outputs");

  AST_HOLD_NO_GATE: assert property (
    (rise && !st_ff.set_cap && !st_ff.rst_cap && !pre_act && !clr_act) |=> $stable(q_o)
  ) else $error("output changed with no gate captured");

  AST_TOGGLE: assert property (
    (rise && st_ff.set_cap && st_ff.rst_cap && !pre_act && !clr_act) |=> (q_o != $past(q_o))
  ) else $error("toggle did not invert output");

  AST_SET_ONLY: assert property (
    (rise && st_ff.set_cap && !st_ff.rst_cap && !pre_act && !clr_act) |=> (q_o && !q_n_o)
  ) else $error("set did not set output");

  AST_CAPTURE: assert property (
    (!clk_lvl && set_term && !pre_act && !clr_act) |=> st_ff.set_cap
  ) else $error("set gate high not captured in clock low");

  AST_PRESET: assert property (
    (pre_act && !clr_act) |=> (q_o && !q_n_o && st_ff.master)
  ) else $error("preset did not force outputs");

  AST_CLEAR: assert property (
    (clr_act && !pre_act) |=> (!q_o && q_n_o && !st_ff.master)
  ) else $error("clear did not force outputs");

  AST_PIN_LATENCY: assert property (
    (!async_clear_n_i && async_preset_n_i) [*5] |=> (!q_o && q_n_o)
  ) else $error("clear pin did not reach outputs in five cycles");

  AST_PRESET_PIN_LATENCY: assert property (
    (!async_preset_n_i && async_clear_n_i) [*5] |=> (q_o && !q_n_o)
  ) else $error("preset pin did not reach outputs in five cycles");

  AST_RESET_ONLY: assert property (
    (rise && !st_ff.set_cap && st_ff.rst_cap && !pre_act && !clr_act) |=> (!q_o && q_n_o)
  ) else $error("reset did not clear output");

  AST_CAPTURE_RST: assert property (
    (!clk_lvl && rst_term && !pre_act && !clr_act) |=> st_ff.rst_cap
  ) else $error("reset gate high not captured in clock low");

  AST_SET_STICKY: assert property (
    (!clk_lvl && st_ff.set_cap && !pre_act && !clr_act) |=> st_ff.set_cap
  ) else $error("set capture lost during clock low");

  AST_RST_STICKY: assert property (
    (!clk_lvl && st_ff.rst_cap && !pre_act && !clr_act) |=> st_ff.rst_cap
  ) else $error("reset capture lost during clock low");

  AST_CAPS_CLEARED: assert property (
    rise |=> (!st_ff.set_cap && !st_ff.rst_cap)
  ) else $error("captures not cleared by rising edge");

  AST_RISE_SINGLE: assert property (
    rise |=> !rise
  ) else $error("rising edge seen twice in a row");

  AST_HIGH_NO_CAPTURE: assert property (
    (clk_lvl && !rise && !pre_act && !clr_act) |=> (!st_ff.set_cap && !st_ff.rst_cap)
  ) else $error("capture taken while flop clock high");

  AST_LOW_OUT_STABLE: assert property (
    (!clk_lvl && !pre_act && !clr_act) |=> $stable(q_o)
  ) else $error("output moved while flop clock low");

  AST_ONLY_ON_RISE: assert property (
    (!rise && !pre_act && !clr_act) |=> ($stable(q_o) && $stable(q_n_o))
  ) else $error("output moved without rising edge or override");

  AST_ASYNC_CLEARS_CAPS: assert property (
    (pre_act || clr_act) |=> (!st_ff.set_cap && !st_ff.rst_cap)
  ) else $error("override left a capture pending");

  AST_GATE_LOW_NO_CAPTURE: assert property (
    (!clk_lvl && !st_ff.filt[gjkff_pkg::IDX_GATE] && !st_ff.set_cap && !st_ff.rst_cap
     && !pre_act && !clr_act) |=> (!st_ff.set_cap && !st_ff.rst_cap)
  ) else $error("capture taken with common gate low");

  AST_MASTER_HOLD: assert property (
    (!clk_lvl && !set_acc && !rst_acc && !pre_act && !clr_act) |=> (st_ff.master == $past(st_ff.q))
  ) else $error("master did not hold");

  AST_MASTER_SET: assert property (
    (!clk_lvl && set_acc && !rst_acc && !pre_act && !clr_act) |=> st_ff.master
  ) else $error("master not set");

  AST_MASTER_CLEAR: assert property (
    (!clk_lvl && !set_acc && rst_acc && !pre_act && !clr_act) |=> !st_ff.master
  ) else $error("master not cleared");

  AST_MASTER_TOGGLE: assert property (
    (!clk_lvl && set_acc && rst_acc && !pre_act && !clr_act) |=> (st_ff.master != $past(st_ff.q))
  ) else $error("master not toggled");

  AST_CLK_FILTER_HIGH: assert property (
    flop_clk_i [*4] |=> clk_lvl
  ) else $error("flop clock high not seen after four samples");

  AST_CLK_FILTER_LOW: assert property (
    !flop_clk_i [*4] |=> !clk_lvl
  ) else $error("flop clock low not seen after four samples");

  AST_GATE_FILTER: assert property (
    common_gate_enable_i [*4] |=> st_ff.filt[gjkff_pkg::IDX_GATE]
  ) else $error("common gate high not seen after four samples");

endmodule
`default_nettype wire

// ### pkg/gjkff_pkg.sv
// constants and state layout for the gated master-slave j-k flop
// Functional notes
// - effective set is AND of three set gates; reset likewise of three reset gates
// - inverting variant inverts one input in each of the set and reset gates
// - common gate low holds the output across a clock pulse
// - gate high: none holds, reset clears, set sets, both toggle
// - next state decided from gate levels during the clock-low interval before the edge
// - gates load the master while clock low; rising edge moves master to outputs
// - while clock is high all synchronous gate inputs are ignored
// - preset or clear forces master and slave regardless of clock and gates
package gjkff_pkg;

  localparam int unsigned N_PINS   = 10;
  localparam int unsigned IDX_CLK  = 0;
  localparam int unsigned IDX_GATE = 1;
  localparam int unsigned IDX_SA   = 2;
  localparam int unsigned IDX_SB   = 3;
  localparam int unsigned IDX_SC   = 4;
  localparam int unsigned IDX_RA   = 5;
  localparam int unsigned IDX_RB   = 6;
  localparam int unsigned IDX_RC   = 7;
  localparam int unsigned IDX_PRE  = 8;
  localparam int unsigned IDX_CLR  = 9;

  // preset and clear idle high after reset, everything else low
  localparam logic [N_PINS-1:0] PIN_RST = 10'h300;
  localparam logic              Q_RST   = 1'h0;
  localparam logic              QN_RST  = 1'h1;

  typedef struct packed {
    logic [N_PINS-1:0] s1;
    logic [N_PINS-1:0] s2;
    logic [N_PINS-1:0] s3;
    logic [N_PINS-1:0] filt;
    logic              clk_prev;
    logic              set_cap;
    logic              rst_cap;
    logic              master;
    logic              q;
    logic              qn;
  } gjkff_state_t;

  localparam gjkff_state_t STATE_RST = '{
    s1: PIN_RST, s2: PIN_RST, s3: PIN_RST, filt: PIN_RST,
    clk_prev: 1'h0, set_cap: 1'h0, rst_cap: 1'h0,
    master: Q_RST, q: Q_RST, qn: QN_RST
  };

endpackage

// ### tb/gjkff_drv.sv
// surrounding logic: flop clock and gate pins
`timescale 1ns/1ps
`default_nettype none
module gjkff_drv (
  input  wire logic       clk_i,
  output logic            flop_clk_o,
  output logic [6:0]      gates_o
);
  initial begin
    flop_clk_o = 1'h0;
    gates_o    = 7'h00;
  end
  // one flop clock pulse; gates held steady from set-up until after the rise
  task automatic pulse(input logic [6:0] g);
    @(negedge clk_i) gates_o = g;
    repeat (4) @(negedge clk_i);
    flop_clk_o = 1'h1;
    @(negedge clk_i) gates_o = 7'h7f;
    repeat (3) @(negedge clk_i);
    gates_o = 7'h00;
    repeat (2) @(negedge clk_i);
    flop_clk_o = 1'h0;
    repeat (4) @(negedge clk_i);
  endtask
endmodule
`default_nettype wire

// ### tb/gjkff_bench.sv
// bench for the gated j-k flop, plain and inverting variants side by side
`timescale 1ns/1ps
`default_nettype none
module gjkff_bench;
  logic       clk_i, resetn_i, pre_n, clr_n, fclk;
  logic [6:0] g;
  logic [1:0] q, qn, exp_q;
  int         errors, n_compared;
  logic [6:0] tbl [9] = '{7'h3f, 7'h43, 7'h7f, 7'h6d, 7'h47, 7'h45, 7'h78, 7'h68, 7'h40};
  gjkff_drv i_drv (.clk_i(clk_i), .flop_clk_o(fclk), .gates_o(g));
  for (genvar i = 0; i < 2; i++) begin : g_v
    gjkff_core #(.INV_GATING(i == 1)) i_dut (.clk_i(clk_i), .resetn_i(resetn_i),
      .flop_clk_i(fclk), .common_gate_enable_i(g[6]), .set_gate_in_a_i(g[0]),
      .set_gate_in_b_i(g[1]), .set_gate_in_c_i(g[2]), .reset_gate_in_a_i(g[3]),
      .reset_gate_in_b_i(g[4]), .reset_gate_in_c_i(g[5]), .async_preset_n_i(pre_n),
      .async_clear_n_i(clr_n), .q_o(q[i]), .q_n_o(qn[i]));
  end
  function automatic logic step(logic cur, logic [6:0] v, logic inv);
    logic j, k;
    j = v[6] & v[0] & (v[1] ^ inv) & v[2];
    k = v[6] & v[3] & (v[4] ^ inv) & v[5];
    return (j & k) ? ~cur : j ? 1'h1 : k ? 1'h0 : cur;
  endfunction
  task automatic check(input logic [1:0] e);
    n_compared += 1;
    if ({q, qn} !== {e, ~e}) begin
      errors += 1;
      $display("BAD %0t got %h exp %h", $time, {q, qn}, {e, ~e});
    end
  endtask
  task automatic run(input logic [6:0] v);
    i_drv.pulse(v);
    exp_q = {step(exp_q[1], v, 1'h1), step(exp_q[0], v, 1'h0)};
    check(exp_q);
  endtask
  // nine gate codes, every mode on both variants; high-phase noise must not count
  task automatic t_modes;
    foreach (tbl[n]) run(tbl[n]);
  endtask
  // preset and clear never together
  task automatic t_async;
    @(negedge clk_i) pre_n = 1'h0;
    repeat (6) @(negedge clk_i);
    exp_q = 2'h3;
    check(exp_q);
    pre_n = 1'h1;
    repeat (6) @(negedge clk_i);
    check(exp_q);
    run(7'h7f);
    clr_n = 1'h0;
    repeat (6) @(negedge clk_i);
    exp_q = 2'h0;
    check(exp_q);
    clr_n = 1'h1;
  endtask
  task automatic end_of_test;
    if (errors == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    clk_i = 1'h0;
    forever #2.5 clk_i = ~clk_i;
  end
  // whole run is under two hundred cycles
  initial begin
    #20us;
    errors += 1;
    end_of_test();
  end
  initial begin
    {resetn_i, pre_n, clr_n} = 3'h3;
    errors = 0;
    n_compared = 0;
    exp_q = 2'h0;
    repeat (2) @(negedge clk_i);
    resetn_i = 1'h1;
    check(exp_q);
    t_modes();
    t_async();
    end_of_test();
  end
endmodule
`default_nettype wire
